// ==== rtl/touch_regs_pkg.sv ====
// Constants shared by the button status and LED settings register bank.
// Assumes one 100 MHz clock domain and a serial host link.
package touch_regs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_EFFECT    = 8'h01;
    localparam logic [7:0] OFS_FADE_A    = 8'h02;
    localparam logic [7:0] OFS_DIM_UP    = 8'h06;
    localparam logic [7:0] OFS_CFG_LAST  = 8'h07;
    localparam logic [7:0] OFS_NOW_LOW   = 8'h04;
    localparam logic [7:0] OFS_NOW_HIGH  = 8'h05;
    localparam logic [7:0] OFS_HELD_LOW  = 8'h07;
    localparam logic [7:0] OFS_HELD_HIGH = 8'h08;
    localparam logic [7:0] OFS_FSUM_UP   = 8'h1a;
    localparam logic [7:0] OFS_FSUM_LO   = 8'h1b;
    localparam logic [7:0] OFS_WSUM_UP   = 8'h1c;
    localparam logic [7:0] OFS_WSUM_LO   = 8'h1d;
    localparam logic [7:0] OFS_ID        = 8'h1e;
    localparam logic [7:0] OFS_REV       = 8'h1f;
    // ----------------------------------------
    // Modes, reset values, sizes
    // ----------------------------------------
    localparam logic [2:0]  MODE_OPERATE = 3'h0;
    localparam logic [2:0]  MODE_LED     = 3'h1;
    localparam logic [2:0]  MODE_LAST_OK = 3'h4;
    localparam logic [2:0]  RST_MODE     = 3'h1;
    localparam logic [7:0]  RST_CFG      = 8'h00;
    // Factory contribution of the settings not held in this bank
    localparam logic [15:0] SUM_BASE     = 16'h003b;
    localparam int          CFG_REGS     = 7;
    localparam int          BUTTONS      = 10;
    localparam int          LOW_BUTTONS  = 8;
endpackage

// ==== rtl/button_latch.sv ====
// Button pin synchroniser with momentary and latched status.
// Assumes touch levels arrive asynchronously; clears come from the bank.
`timescale 1ns/10ps
module button_latch #(
    parameter int N = 10
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Touch pins
    input  wire logic [N-1:0] touch_pin,
    // Read-clear strobes for low and high byte
    input  wire logic         clr_low,
    input  wire logic         clr_high,
    // Status
    output logic      [N-1:0] now,
    output logic      [N-1:0] held
);
    logic [N-1:0] pin_meta;
    logic [N-1:0] clr_mask;

    for (genvar i = 0; i < N; i++) begin : g_mask
        assign clr_mask[i] = (i < touch_regs_pkg::LOW_BUTTONS) ? clr_low : clr_high;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta <= '0;
            now      <= '0;
            held     <= '0;
        end else begin
            pin_meta <= touch_pin;
            now      <= pin_meta;
            // A touch in the clearing cycle survives the read
            held     <= (held & ~clr_mask) | now;
        end
    end
endmodule // button_latch

// ==== rtl/settings_sum.sv ====
// Registered 16-bit arithmetic sum of a group of setting bytes.
// Assumes the bytes are packed lowest index in the low bits.
`timescale 1ns/10ps
module settings_sum #(
    parameter int          N    = 7,
    parameter logic [15:0] BASE = 16'h0000
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // Bytes to add
    input  wire logic [8*N-1:0] bytes,
    // Sum, one cycle behind
    output logic      [15:0]    total
);
    logic [15:0] next_total;

    always_comb begin
        next_total = BASE;
        for (int i = 0; i < N; i++) begin
            next_total = next_total + {8'h00, bytes[8*i +: 8]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) total <= BASE;
        else     total <= next_total;
    end
endmodule // settings_sum

// ==== rtl/button_regs.sv ====
// Button status and LED settings register bank behind a two-wire host link.
// Assumes open-drain data and clock wires resolved outside; touch pins async.
//
// Contract
// [RULE1] Buttons 0-7 in bits 7:0 at 04h, buttons 8-9 in bits 1:0 at 05h.
// [RULE2] Status bit is 1 while touched; read-only; zero after power-on.
// [RULE3] Registers 07h/08h hold latched status in the same layout.
// [RULE4] Stored-settings checksum at 1Ah/1Bh, upper byte first, read-only.
// [RULE5] Checksum is the arithmetic sum of the stored setting registers.
// [RULE6] Settings saved to storage become the defaults loaded afterwards.
// [RULE7] Working-copy checksum at 1Ch/1Dh, upper byte first, same ranges.
// [RULE8] Fixed read-only identification byte at 1Eh.
// [RULE9] Read-only firmware revision byte at 1Fh.
// [RULE10] LED mode offset 01h holds the LED effect control fields.
// [RULE11] Three-bit mode selects the map; codes 101-111 are invalid.
// [RULE12] Each register powers up at its listed value; access as listed.
// [RULE13] LED mode offsets 02h-05h are read-write fade periods.
// [RULE14] Dim registers hold ramp, brightness, repeat and timing fields.
`timescale 1ns/10ps
module button_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h37,
    parameter logic [7:0] PART_ID  = 8'h5c, // arbitrary value
    parameter logic [7:0] REV      = 8'h02  // arbitrary value
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Host link
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Touch inputs
    input  wire logic [9:0] button_touch,
    // Settings storage commands
    input  wire logic       save_settings,
    input  wire logic       reload_settings,
    // Settings to the LED logic
    output logic      [2:0] device_mode,
    output logic      [7:0] led_effect_control,
    output logic      [7:0] led_fade_period_a,
    output logic      [7:0] led_fade_period_b,
    output logic      [7:0] led_fade_period_c,
    output logic      [7:0] led_fade_period_d,
    output logic      [7:0] output0_dim_ramp_up,
    output logic      [7:0] output0_dim_ramp_down
);
    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_ADDR  = 7'b0000010,
        S_ACK_A = 7'b0000100,
        S_WRITE = 7'b0001000,
        S_ACK_W = 7'b0010000,
        S_READ  = 7'b0100000,
        S_ACK_R = 7'b1000000
    } link_state_t;

    link_state_t state, next_state;
    logic [2:0]  scl_q, sda_q;
    logic [2:0]  bit_cnt;
    logic        byte_done, rw, first, master_ack, next_oe_n;
    logic [7:0]  shift, tx, ptr, rd_data;
    logic [7:0]  cfg    [1:7];
    logic [7:0]  stored [1:7];
    logic [55:0] cfg_flat, stored_flat;
    logic [9:0]  button_now, button_held;
    logic [15:0] stored_sum, working_sum;

    // ----------------------------------------
    // Link decoding
    // ----------------------------------------
    wire scl_rise   = scl_q[1] & ~scl_q[2];
    wire scl_fall   = ~scl_q[1] & scl_q[2];
    wire sda_now    = sda_q[1];
    wire start      = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    wire stop       = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    wire byte_end   = scl_fall & byte_done;
    wire got_addr   = shift[7:1] == DEV_ADDR;
    wire data_state = state inside {S_ADDR, S_WRITE, S_READ};
    wire wr_pulse   = (state == S_WRITE) & byte_end & ~first;
    wire ptr_pulse  = (state == S_WRITE) & byte_end & first;
    wire load_pulse = scl_fall & (((state == S_ACK_A) & rw) | ((state == S_ACK_R) & master_ack));
    wire op_map     = device_mode == touch_regs_pkg::MODE_OPERATE;
    wire led_map    = device_mode == touch_regs_pkg::MODE_LED;
    wire cfg_we     = wr_pulse & led_map & (ptr >= touch_regs_pkg::OFS_EFFECT)
                      & (ptr <= touch_regs_pkg::OFS_CFG_LAST);
    wire mode_we    = wr_pulse & (ptr == touch_regs_pkg::OFS_MODE)
                      & (shift[2:0] <= touch_regs_pkg::MODE_LAST_OK);
    wire clr_low    = load_pulse & op_map & (ptr == touch_regs_pkg::OFS_HELD_LOW);
    wire clr_high   = load_pulse & op_map & (ptr == touch_regs_pkg::OFS_HELD_HIGH);

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_in};
            sda_q <= {sda_q[1:0], sda_in};
        end
    end

    // ----------------------------------------
    // Link state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_oe_n  = sda_oe_n;
        case (state)
            S_IDLE: ;
            S_ADDR: if (byte_end) begin
                next_state = got_addr ? S_ACK_A : S_IDLE;
                next_oe_n  = ~got_addr;
            end
            S_ACK_A: if (scl_fall) begin
                next_state = rw ? S_READ : S_WRITE;
                next_oe_n  = rw ? rd_data[7] : 1'b1;
            end
            S_WRITE: if (byte_end) begin
                next_state = S_ACK_W;
                next_oe_n  = 1'b0;
            end
            S_ACK_W: if (scl_fall) begin
                next_state = S_WRITE;
                next_oe_n  = 1'b1;
            end
            S_READ: if (byte_end) begin
                next_state = S_ACK_R;
                next_oe_n  = 1'b1;
            end else if (scl_fall) begin
                next_oe_n  = tx[6];
            end
            S_ACK_R: if (scl_fall) begin
                next_state = master_ack ? S_READ : S_IDLE;
                next_oe_n  = master_ack ? rd_data[7] : 1'b1;
            end
            default: next_state = S_IDLE;
        endcase
        // Bus conditions override any byte in flight
        if (start) begin
            next_state = S_ADDR;
            next_oe_n  = 1'b1;
        end else if (stop) begin
            next_state = S_IDLE;
            next_oe_n  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= S_IDLE;
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
        end else begin
            state    <= next_state;
            sda_oe_n <= next_oe_n;
            sda_out  <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || start) begin
            bit_cnt   <= 3'h0;
            byte_done <= 1'b0;
        end else if (scl_rise && data_state) begin
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= bit_cnt == 3'h7;
        end else if (scl_fall) begin
            byte_done <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift      <= 8'h00;
            tx         <= 8'h00;
            ptr        <= 8'h00;
            rw         <= 1'b0;
            first      <= 1'b0;
            master_ack <= 1'b0;
        end else begin
            if (scl_rise && (state == S_ADDR || state == S_WRITE)) shift <= {shift[6:0], sda_now};
            if (scl_rise && state == S_ACK_R) master_ack <= ~sda_now;
            if (state == S_ADDR && byte_end) begin
                rw    <= shift[0];
                first <= 1'b1;
            end
            if (ptr_pulse) begin
                ptr   <= shift;
                first <= 1'b0;
            end
            // Auto-increment so multi-byte writes and reads walk the map
            if (wr_pulse) ptr <= ptr + 8'h01;
            if (load_pulse) begin
                tx  <= rd_data;
                ptr <= ptr + 8'h01;
            end else if (state == S_READ && scl_fall) begin
                tx  <= {tx[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Read map
    // ----------------------------------------
    always_comb begin
        rd_data = 8'h00;
        if (ptr == touch_regs_pkg::OFS_MODE) begin
            rd_data = {5'h00, device_mode};
        end else if (op_map) begin
            case (ptr)
                touch_regs_pkg::OFS_NOW_LOW:   rd_data = button_now[7:0]; // RULE1
                touch_regs_pkg::OFS_NOW_HIGH:  rd_data = {6'h00, button_now[9:8]}; // RULE1
                touch_regs_pkg::OFS_HELD_LOW:  rd_data = button_held[7:0]; // RULE3
                touch_regs_pkg::OFS_HELD_HIGH: rd_data = {6'h00, button_held[9:8]}; // RULE3
                touch_regs_pkg::OFS_FSUM_UP:   rd_data = stored_sum[15:8]; // RULE4
                touch_regs_pkg::OFS_FSUM_LO:   rd_data = stored_sum[7:0]; // RULE4
                touch_regs_pkg::OFS_WSUM_UP:   rd_data = working_sum[15:8]; // RULE7
                touch_regs_pkg::OFS_WSUM_LO:   rd_data = working_sum[7:0]; // RULE7
                touch_regs_pkg::OFS_ID:        rd_data = PART_ID; // RULE8
                touch_regs_pkg::OFS_REV:       rd_data = REV; // RULE9
                default:                       rd_data = 8'h00;
            endcase
        end else if (led_map && ptr <= touch_regs_pkg::OFS_CFG_LAST) begin
            rd_data = cfg[ptr[2:0]]; // RULE13
        end
    end

    // ----------------------------------------
    // Settings: working copy and stored copy
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            device_mode <= touch_regs_pkg::RST_MODE; // RULE12
            for (int i = 1; i <= touch_regs_pkg::CFG_REGS; i++) begin
                cfg[i]    <= touch_regs_pkg::RST_CFG; // RULE12
                stored[i] <= touch_regs_pkg::RST_CFG;
            end
        end else begin
            if (mode_we) device_mode <= shift[2:0]; // RULE11
            for (int i = 1; i <= touch_regs_pkg::CFG_REGS; i++) begin
                if (save_settings) stored[i] <= cfg[i];
                if (reload_settings) cfg[i] <= stored[i]; // RULE6
                else if (cfg_we && ptr[2:0] == 3'(i)) cfg[i] <= shift; // RULE10
            end
        end
    end

    for (genvar i = 0; i < touch_regs_pkg::CFG_REGS; i++) begin : g_flat
        assign cfg_flat[8*i +: 8]    = cfg[i+1];
        assign stored_flat[8*i +: 8] = stored[i+1];
    end

    // Whole bytes go out; the LED logic slices the fields itself
    assign led_effect_control    = cfg[1]; // RULE10
    assign led_fade_period_a     = cfg[2]; // RULE13
    assign led_fade_period_b     = cfg[3];
    assign led_fade_period_c     = cfg[4];
    assign led_fade_period_d     = cfg[5];
    assign output0_dim_ramp_up   = cfg[6]; // RULE14
    assign output0_dim_ramp_down = cfg[7]; // RULE14

    settings_sum #(.N(touch_regs_pkg::CFG_REGS), .BASE(touch_regs_pkg::SUM_BASE)) u_stored_sum (
        .clk   (clk),
        .rst   (rst),
        .bytes (stored_flat),
        .total (stored_sum)
    ); // RULE5

    settings_sum #(.N(touch_regs_pkg::CFG_REGS), .BASE(touch_regs_pkg::SUM_BASE)) u_working_sum (
        .clk   (clk),
        .rst   (rst),
        .bytes (cfg_flat),
        .total (working_sum)
    ); // RULE7

    button_latch #(.N(touch_regs_pkg::BUTTONS)) u_buttons (
        .clk       (clk),
        .rst       (rst),
        .touch_pin (button_touch),
        .clr_low   (clr_low),
        .clr_high  (clr_high),
        .now       (button_now),
        .held      (button_held)
    ); // RULE2

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_now_low_map: assert property ( // RULE1
        (load_pulse && op_map && ptr == touch_regs_pkg::OFS_NOW_LOW)
        |=> tx == $past(button_now[7:0])) else $error("low status byte wrong");
    a_now_high_pad: assert property ( // RULE1
        (load_pulse && op_map && ptr == touch_regs_pkg::OFS_NOW_HIGH)
        |=> tx == {6'h00, $past(button_now[9:8])}) else $error("high status byte wrong");
    a_held_sets: assert property ( // RULE3
        ##1 1'b1 |-> (button_held & $past(button_now)) == $past(button_now))
        else $error("touch not latched");
    a_stored_sum_calc: assert property ( // RULE5
        (save_settings && !cfg_we && !reload_settings) |-> ##2 stored_sum == working_sum)
        else $error("stored sum mismatch");
    a_sum_upper_first: assert property ( // RULE4
        (load_pulse && op_map && ptr == touch_regs_pkg::OFS_FSUM_UP)
        |=> tx == $past(stored_sum[15:8])) else $error("stored sum order wrong");
    a_reload_defaults: assert property ( // RULE6
        reload_settings |=> led_effect_control == $past(stored[1]))
        else $error("reload did not restore");
    a_id_value: assert property ( // RULE8
        (load_pulse && op_map && ptr == touch_regs_pkg::OFS_ID) |=> tx == PART_ID)
        else $error("identity byte wrong");
    a_rev_value: assert property ( // RULE9
        (load_pulse && op_map && ptr == touch_regs_pkg::OFS_REV) |=> tx == REV)
        else $error("revision byte wrong");
    a_effect_write: assert property ( // RULE10
        (cfg_we && !reload_settings && ptr == touch_regs_pkg::OFS_EFFECT)
        |=> led_effect_control == $past(shift)) else $error("effect write lost");
    a_mode_invalid: assert property ( // RULE11
        (wr_pulse && ptr == touch_regs_pkg::OFS_MODE && shift[2:0] > 3'h4)
        |=> $stable(device_mode)) else $error("invalid mode accepted");
    a_reset_values: assert property ( // RULE12
        $fell(rst) |-> device_mode == touch_regs_pkg::RST_MODE && led_effect_control == 8'h00)
        else $error("reset values wrong");
    a_fade_write: assert property ( // RULE13
        (cfg_we && !reload_settings && ptr == touch_regs_pkg::OFS_FADE_A)
        |=> led_fade_period_a == $past(shift)) else $error("fade write lost");
    a_dim_write: assert property ( // RULE14
        (cfg_we && !reload_settings && ptr == touch_regs_pkg::OFS_DIM_UP)
        |=> output0_dim_ramp_up == $past(shift)) else $error("dim write lost");

    c_read_byte:  cover property (load_pulse ##[1:200] state == S_ACK_R);
    c_write_byte: cover property (cfg_we);
    c_mode_write: cover property (mode_we ##1 led_map);
endmodule // button_regs

// ==== tb/link_host.sv ====
// Host master model for the two-wire register link of the button bank.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module link_host (
    // Clock
    input  wire logic clk,
    // Link wires
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // ----------------------------------------
    // Wire phases
    // ----------------------------------------
    // Four clocks a phase, well past the two-stage input synchronisers
    task automatic quarter();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Also a repeated start when entered with the clock low
    task automatic start();
        sda_low = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sda_low = 1'b1;
        quarter();
        scl = 1'b0;
        quarter();
    endtask
    task automatic stop();
        sda_low = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sda_low = 1'b0;
        quarter();
    endtask
    // Sent 1 releases the wire, so reads and acks share this
    task automatic bit_io(input logic b, output logic seen);
        sda_low = ~b;
        quarter();
        scl = 1'b1;
        quarter();
        seen = sda_line;
        quarter();
        scl = 1'b0;
        quarter();
    endtask
    // ----------------------------------------
    // Bytes
    // ----------------------------------------
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic read_byte(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, s);
    endtask
endmodule // link_host

// ==== tb/tb_top.sv ====
// Self-checking bench for the button status and LED settings bank.
// Assumes the host model above and a pulled-up data wire.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; $display("Error %s expected %h seen %h", what, exp, got); end end
module tb_top;
    localparam logic [6:0] ADDR = 7'h37;
    localparam logic [7:0] ID   = 8'h5c; // arbitrary value
    localparam logic [7:0] REV  = 8'h02; // arbitrary value
    logic        clk, rst, scl, sda_low, sda_line, sda_out, sda_oe_n;
    logic        save_settings, reload_settings;
    logic [9:0]  button_touch;
    logic [2:0]  device_mode;
    logic [7:0]  led_effect_control, output0_dim_ramp_up, output0_dim_ramp_down;
    logic [7:0]  led_fade_period_a, led_fade_period_b, led_fade_period_c, led_fade_period_d;
    logic [15:0] cfg_sum;
    int          fails = 0;
    int          total_checks = 0;
    assign sda_line = ~sda_low & (sda_oe_n | sda_out);
    button_regs #(.DEV_ADDR(ADDR), .PART_ID(ID), .REV(REV)) u_dut (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .button_touch(button_touch), .save_settings(save_settings),
        .reload_settings(reload_settings), .device_mode(device_mode),
        .led_effect_control(led_effect_control), .led_fade_period_a(led_fade_period_a),
        .led_fade_period_b(led_fade_period_b), .led_fade_period_c(led_fade_period_c),
        .led_fade_period_d(led_fade_period_d), .output0_dim_ramp_up(output0_dim_ramp_up),
        .output0_dim_ramp_down(output0_dim_ramp_down));
    link_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    // ----------------------------------------
    // Register access
    // ----------------------------------------
    task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
        logic a;
        u_host.start();
        u_host.write_byte({ADDR, 1'b0}, a);
        u_host.write_byte(ofs, a);
        u_host.write_byte(val, a);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] ofs, input int n, output logic [15:0] v);
        logic       a;
        logic [7:0] b;
        v = 16'h0000;
        u_host.start();
        u_host.write_byte({ADDR, 1'b0}, a);
        u_host.write_byte(ofs, a);
        u_host.start();
        u_host.write_byte({ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            u_host.read_byte(b, i == n - 1);
            v = {v[7:0], b};
        end
        u_host.stop();
    endtask
    task automatic strobe(input logic save);
        save_settings   = save;
        reload_settings = ~save;
        @(posedge clk);
        #1;
        save_settings   = 1'b0;
        reload_settings = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [15:0] v;
        `CHK("mode port", 3'h1, device_mode)
        `CHK("effect port", 8'h00, led_effect_control)
        rd(8'h00, 1, v);
        `CHK("mode reg", 16'h0001, v)
        wr(8'h00, 8'h00);
        rd(8'h1a, 2, v);
        `CHK("stored sum", 16'h003b, v)
        rd(8'h1c, 2, v);
        `CHK("working sum", 16'h003b, v)
        wr(8'h1e, 8'hff);
        rd(8'h1e, 2, v);
        `CHK("identity", ID, v[15:8])
        `CHK("revision", REV, v[7:0])
        rd(8'h04, 2, v);
        `CHK("status at reset", 16'h0000, v)
    endtask
    task automatic t_modes();
        logic [15:0] v;
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, 8'(m));
            `CHK("mode port", (m > 4) ? 3'h4 : 3'(m), device_mode)
        end
        // Debug map shows only the mode byte
        rd(8'h1e, 1, v);
        `CHK("identity in debug map", 16'h0000, v)
        rd(8'h00, 1, v);
        `CHK("mode in debug map", 16'h0004, v)
    endtask
    task automatic t_led();
        logic [15:0] v;
        logic [7:0]  b;
        logic        a;
        wr(8'h00, 8'h01);
        u_host.start();
        u_host.write_byte({ADDR, 1'b0}, a);
        u_host.write_byte(8'h01, a);
        b       = 8'h00;
        cfg_sum = 16'h003b;
        for (int i = 1; i < 8; i++) begin
            b = b + 8'h23;
            cfg_sum = cfg_sum + {8'h00, b};
            u_host.write_byte(b, a);
        end
        u_host.stop();
        `CHK("effect port", 8'h23, led_effect_control)
        `CHK("fade ports", 32'h46698caf, {led_fade_period_a, led_fade_period_b, led_fade_period_c, led_fade_period_d})
        `CHK("dim ports", 16'hd2f5, {output0_dim_ramp_up, output0_dim_ramp_down})
        rd(8'h01, 2, v);
        `CHK("effect readback", 16'h2346, v)
        wr(8'h00, 8'h00);
        wr(8'h01, 8'hff);
        `CHK("effect in other map", 8'h23, led_effect_control)
        rd(8'h1c, 2, v);
        `CHK("working sum", cfg_sum, v)
        rd(8'h1a, 2, v);
        `CHK("stored sum unsaved", 16'h003b, v)
    endtask
    task automatic t_store();
        logic [15:0] v;
        strobe(1'b1);
        rd(8'h1a, 2, v);
        `CHK("stored sum", cfg_sum, v)
        wr(8'h00, 8'h01);
        wr(8'h01, 8'h5a);
        `CHK("effect port", 8'h5a, led_effect_control)
        strobe(1'b0);
        `CHK("reloaded effect", 8'h23, led_effect_control)
        wr(8'h00, 8'h00);
        rd(8'h1c, 2, v);
        `CHK("working sum", cfg_sum, v)
    endtask
    task automatic t_buttons();
        logic [15:0] v;
        button_touch = 10'h2a5;
        repeat (6) @(posedge clk);
        #1;
        rd(8'h04, 2, v);
        `CHK("touch status", 16'ha502, v)
        wr(8'h04, 8'hff);
        rd(8'h04, 1, v);
        `CHK("status read-only", 16'h00a5, v)
        button_touch = 10'h000;
        repeat (6) @(posedge clk);
        #1;
        rd(8'h04, 2, v);
        `CHK("release status", 16'h0000, v)
        rd(8'h07, 1, v);
        `CHK("held low", 16'h00a5, v)
        rd(8'h08, 1, v);
        `CHK("held high", 16'h0002, v)
        rd(8'h07, 1, v);
        `CHK("held cleared", 16'h0000, v)
    endtask
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is near 22k cycles; a hung link gets over four and a half times that
    initial begin
        #1000000;
        fails++;
        $display("Error watchdog expected finish seen timeout");
        final_report();
    end
    initial begin
        rst             = 1'b1;
        button_touch    = 10'h000;
        save_settings   = 1'b0;
        reload_settings = 1'b0;
        cfg_sum         = 16'h003b;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_modes();
        t_led();
        t_store();
        t_buttons();
        final_report();
    end
endmodule // tb_top
